// [fbc_pkg.sv]
package fbc_pkg;
  // bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  // command addresses and codes
  localparam logic [19:0] UNLOCK_ADDR_1  = 20'h00555;
  localparam logic [19:0] UNLOCK_ADDR_2  = 20'h002AA;
  localparam logic [19:0] ID_MFR_ADDR    = 20'h00000;
  localparam logic [19:0] ID_DEV_ADDR    = 20'h00001;
  localparam logic [19:0] PROT_ADDR_MASK = 20'hFE000;
  localparam logic [19:0] PROT_ADDR_LOW  = 20'h00002;
  localparam logic [7:0]  UNLOCK_DATA_1  = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_2  = 8'h55;
  localparam logic [7:0]  CMD_RESET      = 8'hF0;
  localparam logic [7:0]  CMD_ID         = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERASE = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0]  CMD_RESUME     = 8'h30;
  // host operations
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_RESET   = 4'h1;
  localparam logic [3:0] OP_ID      = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_CHIP_ER = 4'h4;
  localparam logic [3:0] OP_SECT_ER = 4'h5;
  localparam logic [3:0] OP_SUSPEND = 4'h6;
  localparam logic [3:0] OP_RESUME  = 4'h7;
  localparam logic [3:0] OP_BYP_PRG = 4'h8;
  localparam logic [3:0] OP_HW_RST  = 4'h9;
  // timing
  localparam int CLK_NS          = 20;
  localparam int ACCESS_NS       = 90;
  localparam int WRITE_PULSE_NS  = 45;
  localparam int RESET_PULSE_NS  = 500;
  localparam int RESET_READ_NS   = 50;
  localparam int ACCESS_CYC      = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC       = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_READ_CYC  = (RESET_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W           = 8;
  localparam int SEQ_W           = 3;
  localparam logic [SEQ_W-1:0] SEQ_ZERO = 3'h0;
  localparam logic [SEQ_W-1:0] SEQ_ONE  = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  typedef enum logic [5:0] {
    FBC_IDLE  = 6'b000001,
    FBC_SETUP = 6'b000010,
    FBC_PULSE = 6'b000100,
    FBC_GAP   = 6'b001000,
    FBC_RD    = 6'b010000,
    FBC_RST   = 6'b100000
  } fbc_state_t;
endpackage

// [fbc_host.sv]
`timescale 1ns/1ns
// How it works
// - reads drive select and gate low, strobe high, then sample data.
// - writes drive strobe and select low with gate held high.
// - bypass program sends only the two final cycles.
// - user restarts cut operations; done output marks the reset.
// - after reset release the host waits before any read.
// - reset op writes F0H after a failed program or erase.
module fbc_host (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_op,
  input  wire logic [19:0] req_addr,
  input  wire logic [7:0]  req_data,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             dev_busy,
  output logic [19:0]      flash_addr,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [7:0]  flash_dq_in,
  output logic             flash_cs_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_reset_n,
  input  wire logic        flash_done_flag
);
  fbc_pkg::fbc_state_t state_q, state_d;
  logic [fbc_pkg::SEQ_W-1:0] seq_q;
  logic [fbc_pkg::SEQ_W-1:0] len_q;
  logic [fbc_pkg::CNT_W-1:0] cnt_q;
  logic [3:0]                op_q;
  logic [19:0]               uaddr_q;
  logic [7:0]                udata_q;
  logic [19:0]               cyc_addr;
  logic [7:0]                cyc_data;
  logic [fbc_pkg::SEQ_W-1:0] req_len;
  logic                      is_read;
  logic                      cnt_done;
  logic                      last_cyc;
  assign cnt_done = (cnt_q == fbc_pkg::CNT_ZERO);
  assign last_cyc = (seq_q == len_q - fbc_pkg::SEQ_ONE);
  assign is_read  = (req_op == fbc_pkg::OP_READ);
  // sequence length per operation
  assign req_len = (req_op == fbc_pkg::OP_RESET || req_op == fbc_pkg::OP_SUSPEND ||
                    req_op == fbc_pkg::OP_RESUME) ? 3'd1 :
                   (req_op == fbc_pkg::OP_ID) ? 3'd3 :
                   (req_op == fbc_pkg::OP_BYP_PRG) ? 3'd2 :
                   (req_op == fbc_pkg::OP_PROGRAM) ? 3'd4 : 3'd6;
  always_comb
  begin
    cyc_addr = fbc_pkg::UNLOCK_ADDR_1;
    cyc_data = fbc_pkg::UNLOCK_DATA_1;
    unique case (op_q)
      fbc_pkg::OP_RESET:
      begin
        cyc_addr = uaddr_q;
        cyc_data = fbc_pkg::CMD_RESET;
      end
      fbc_pkg::OP_SUSPEND:
      begin
        cyc_addr = uaddr_q;
        cyc_data = fbc_pkg::CMD_SUSPEND;
      end
      fbc_pkg::OP_RESUME:
      begin
        cyc_addr = uaddr_q;
        cyc_data = fbc_pkg::CMD_RESUME;
      end
      fbc_pkg::OP_BYP_PRG:
      begin
        cyc_addr = (seq_q == fbc_pkg::SEQ_ZERO) ? fbc_pkg::UNLOCK_ADDR_1 : uaddr_q;
        cyc_data = (seq_q == fbc_pkg::SEQ_ZERO) ? fbc_pkg::CMD_PROGRAM : udata_q;
      end
      default:
      begin
        unique case (seq_q)
          3'd0:
          begin
            cyc_addr = fbc_pkg::UNLOCK_ADDR_1;
            cyc_data = fbc_pkg::UNLOCK_DATA_1;
          end
          3'd1, 3'd4:
          begin
            cyc_addr = fbc_pkg::UNLOCK_ADDR_2;
            cyc_data = fbc_pkg::UNLOCK_DATA_2;
          end
          3'd2:
          begin
            cyc_addr = fbc_pkg::UNLOCK_ADDR_1;
            cyc_data = (op_q == fbc_pkg::OP_ID) ? fbc_pkg::CMD_ID :
                       (op_q == fbc_pkg::OP_PROGRAM) ? fbc_pkg::CMD_PROGRAM :
                       fbc_pkg::CMD_ERASE_SET;
          end
          3'd3:
          begin
            cyc_addr = (op_q == fbc_pkg::OP_PROGRAM) ? uaddr_q : fbc_pkg::UNLOCK_ADDR_1;
            cyc_data = (op_q == fbc_pkg::OP_PROGRAM) ? udata_q : fbc_pkg::UNLOCK_DATA_1;
          end
          default:
          begin
            cyc_addr = (op_q == fbc_pkg::OP_SECT_ER) ? uaddr_q : fbc_pkg::UNLOCK_ADDR_1;
            cyc_data = (op_q == fbc_pkg::OP_SECT_ER) ? fbc_pkg::CMD_SECT_ERASE :
                       fbc_pkg::CMD_CHIP_ERASE;
          end
        endcase
      end
    endcase
  end
  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      fbc_pkg::FBC_IDLE:
        if (req_valid)
          state_d = is_read ? fbc_pkg::FBC_RD :
                    (req_op == fbc_pkg::OP_HW_RST) ? fbc_pkg::FBC_RST : fbc_pkg::FBC_SETUP;
      fbc_pkg::FBC_SETUP:
        state_d = fbc_pkg::FBC_PULSE;
      fbc_pkg::FBC_PULSE:
        if (cnt_done)
          state_d = fbc_pkg::FBC_GAP;
      fbc_pkg::FBC_GAP:
        state_d = last_cyc ? fbc_pkg::FBC_IDLE : fbc_pkg::FBC_SETUP;
      fbc_pkg::FBC_RD:
        if (cnt_done)
          state_d = fbc_pkg::FBC_IDLE;
      fbc_pkg::FBC_RST:
        if (cnt_done && flash_reset_n)
          state_d = fbc_pkg::FBC_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= fbc_pkg::FBC_IDLE;
    else
      state_q <= state_d;
  end
  // counters and captured request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_q   <= fbc_pkg::SEQ_ZERO;
      len_q   <= fbc_pkg::SEQ_ZERO;
      op_q    <= fbc_pkg::OP_READ;
      uaddr_q <= 20'h00000;
      udata_q <= 8'h00;
      cnt_q   <= fbc_pkg::CNT_ZERO;
    end
    else if (state_q == fbc_pkg::FBC_IDLE && req_valid)
    begin
      seq_q   <= fbc_pkg::SEQ_ZERO;
      len_q   <= req_len;
      op_q    <= req_op;
      uaddr_q <= req_addr;
      udata_q <= req_data;
      cnt_q   <= (req_op == fbc_pkg::OP_HW_RST) ? 8'(fbc_pkg::RESET_PULSE_CYC - 1) :
                 8'(fbc_pkg::ACCESS_CYC);
    end
    else if (state_q == fbc_pkg::FBC_SETUP)
      cnt_q <= 8'(fbc_pkg::WRITE_CYC);
    else if (state_q == fbc_pkg::FBC_GAP)
      seq_q <= seq_q + fbc_pkg::SEQ_ONE;
    else if (state_q == fbc_pkg::FBC_RST && cnt_done && !flash_reset_n)
      cnt_q <= 8'(fbc_pkg::RESET_READ_CYC);
    else if (!cnt_done)
      cnt_q <= cnt_q - fbc_pkg::CNT_ONE;
  end
  // pin drive
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_addr    <= 20'h00000;
      flash_dq_out  <= 8'h00;
      flash_dq_oe   <= 1'b0;
      flash_cs_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
    end
    else
    begin
      // stable address and data for the write
      flash_addr    <= (state_d == fbc_pkg::FBC_RD && state_q == fbc_pkg::FBC_IDLE) ?
                       req_addr : (state_d == fbc_pkg::FBC_RD) ? flash_addr : cyc_addr;
      flash_dq_out  <= cyc_data;
      flash_dq_oe   <= (state_d == fbc_pkg::FBC_SETUP || state_d == fbc_pkg::FBC_PULSE ||
                        state_d == fbc_pkg::FBC_GAP);
      flash_we_n    <= !(state_d == fbc_pkg::FBC_PULSE && state_q == fbc_pkg::FBC_PULSE);
      flash_cs_n    <= !(state_d == fbc_pkg::FBC_PULSE || state_d == fbc_pkg::FBC_RD);
      flash_oe_n    <= !(state_d == fbc_pkg::FBC_RD);
      flash_reset_n <= !(state_d == fbc_pkg::FBC_RST && !(state_q == fbc_pkg::FBC_RST &&
                         (cnt_done || flash_reset_n)));
    end
  end
  // user side
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      dev_busy  <= 1'b0;
    end
    else
    begin
      req_ready <= (state_d == fbc_pkg::FBC_IDLE) && !(state_q == fbc_pkg::FBC_IDLE && req_valid);
      rsp_valid <= (state_q == fbc_pkg::FBC_RD && cnt_done) ||
                   (state_q == fbc_pkg::FBC_GAP && last_cyc) ||
                   (state_q == fbc_pkg::FBC_RST && state_d == fbc_pkg::FBC_IDLE);
      if (state_q == fbc_pkg::FBC_RD && cnt_done)
        rsp_data <= flash_dq_in;
      dev_busy  <= !flash_done_flag;
    end
  end
endmodule

// [fbc_host_monitor.sv]
`timescale 1ns/1ns
module fbc_host_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic [3:0]  req_op,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        dev_busy,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0]  flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_cs_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_reset_n,
  input wire logic        flash_done_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_take(logic [3:0] op);
    req_valid && req_ready && req_op == op;
  endsequence
  sequence s_wr(logic [19:0] a, logic [7:0] d);
    !flash_we_n && flash_addr == a && flash_dq_out == d;
  endsequence
  a_read_strobe: assert property (
    !flash_oe_n |-> flash_we_n && !flash_cs_n && !flash_dq_oe)
    else $error("gate low while strobe low or host driving");
  a_write_pins: assert property (
    !flash_we_n |-> !flash_cs_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe without select or with gate low");
  a_write_hold: assert property (
    $fell(flash_we_n) |-> $stable(flash_addr) ##1 (!flash_we_n && $stable(flash_addr) &&
    $stable(flash_dq_out))[*2] ##1 flash_we_n)
    else $error("address or data moved during write pulse");
  a_idle_standby: assert property (
    req_ready |-> flash_cs_n && flash_oe_n && flash_we_n && flash_reset_n)
    else $error("pins not in standby while idle");
  a_reset_pulse: assert property (
    $fell(flash_reset_n) |-> !flash_reset_n throughout (1'b1 ##24 1'b1))
    else $error("hardware reset pulse too short");
  a_reset_read: assert property (
    $rose(flash_reset_n) |-> flash_oe_n [*3]) else $error("read too soon after reset");
  a_busy_follow: assert property (
    1'b1 |=> dev_busy == !$past(flash_done_flag)) else $error("busy does not follow flag");
  a_read_answer: assert property (
    s_take(fbc_pkg::OP_READ) |=> !rsp_valid [*6] ##1 rsp_valid)
    else $error("read answer not on time");
  a_unlock_first: assert property (
    s_take(fbc_pkg::OP_PROGRAM) |-> ##[1:4] s_wr(20'h00555, 8'hAA))
    else $error("program does not open with unlock cycle");
  a_reset_cmd: assert property (
    s_take(fbc_pkg::OP_RESET) |-> ##[1:4] (!flash_we_n && flash_dq_out == 8'hF0))
    else $error("reset command not written");
endmodule
bind fbc_host fbc_host_monitor u_mon (.clk_sys, .rst_n, .req_valid, .req_op, .req_ready,
  .rsp_valid, .dev_busy, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_cs_n,
  .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_done_flag);

// [fbc_flash_model.sv]
`timescale 1ns/1ns
module fbc_flash_model (
  input  wire logic        clk_sys,
  input  wire logic [19:0] flash_addr,
  input  wire logic [7:0]  flash_dq,
  input  wire logic        flash_cs_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_reset_n,
  output logic             flash_done_flag,
  output logic             mdl_en,
  output logic [7:0]       mdl_dq
);
  // arbitrary identification values
  localparam logic [7:0] MFR_CODE = 8'h6B;
  localparam logic [7:0] DEV_CODE = 8'h4D;
  logic [7:0]  mem [256];
  logic [7:0]  rd, d, pd, pa;
  logic [10:0] a;
  int          step = 0, busy = 0, pk = 0;
  bit          idm = 0, prg = 0, sus = 0, sel = 0;
  initial foreach (mem[i]) mem[i] = 8'(i);
  // drive only for a selected read
  assign mdl_en = flash_reset_n && !flash_cs_n && !flash_oe_n && flash_we_n;
  assign rd = !idm ? mem[flash_addr[7:0]] : flash_addr[1] ? {7'h00, flash_addr[13]} :
              flash_addr[0] ? DEV_CODE : MFR_CODE;
  assign #60 mdl_dq = rd;
  assign flash_done_flag = busy == 0 || sus;
  // address on the falling edge, data on the rising edge
  always @(negedge flash_we_n)
  begin
    a = flash_addr[10:0];
    #1 sel = !flash_cs_n;
  end
  always @(posedge flash_we_n)
    if (sel && flash_reset_n)
    begin
      sel = 0;
      d = flash_dq;
      // an erasing device only hears suspend and resume; a programming one hears nothing
      if (busy > 0)
        sus = (pk == 2 && d == 8'hB0) ? 1 : (pk == 2 && d == 8'h30) ? 0 : sus;
      // reset returns to array read; wrong cycles only restart the unlock sequence
      else if (d == 8'hF0) {step, idm} = 0;
      else if (prg) {prg, pa, pd, pk, busy} = {1'b0, a[7:0], d, 32'd1, 32'd15};
      else if (step == 0 && a == 11'h555 && d == 8'hAA) step = 1;
      else if (step == 3 && a == 11'h555 && d == 8'hAA) step = 4;
      else if (step % 3 == 1 && a == 11'h2AA && d == 8'h55) step = step + 1;
      else if (step == 2 && a == 11'h555 && d == 8'h90) {idm, step} = {1'b1, 32'd0};
      else if (step == 2 && a == 11'h555 && d == 8'h80) step = 3;
      // bypass program needs no unlock cycles
      else if (step % 2 == 0 && step < 3 && a == 11'h555 && d == 8'hA0)
        {prg, step} = {1'b1, 32'd0};
      else if (step == 5 && (d == 8'h10 || d == 8'h30)) {pk, busy, step} = {32'd2, 32'd100, 32'd0};
      else step = 0;
    end
  // results land when the algorithm ends
  always @(negedge clk_sys)
    if (busy > 0 && !sus)
    begin
      busy = busy - 1;
      if (busy == 0 && pk == 1) mem[pa] = pd;
      if (busy == 0 && pk == 2) foreach (mem[i]) mem[i] = 8'hFF;
    end
  // reset aborts; busy clears after a short recovery
  always @(negedge flash_reset_n)
  begin
    {step, pk, idm, prg, sus} = 0;
    busy = busy > 0 ? 3 : 0;
  end
endmodule

// [tb_fbc_host.sv]
`timescale 1ns/1ns
module tb_fbc_host;
  typedef struct {logic [3:0] op; logic [19:0] a; logic [7:0] d, x; bit c, b, w;} fbc_row_t;
  logic        clk_sys = 0, rst_n = 0, req_valid = 0;
  logic [3:0]  req_op = 0;
  logic [19:0] req_addr = 0, flash_addr;
  logic [7:0]  req_data = 0, dq_hold = 0, rsp_data, flash_dq_out, mdl_dq, flash_dq_in;
  logic        req_ready, rsp_valid, dev_busy, flash_dq_oe, flash_cs_n, flash_oe_n;
  logic        flash_we_n, flash_reset_n, flash_done_flag, mdl_en;
  int          err_total = 0, check_count = 0;
  fbc_row_t    rows [21] = '{'{0, 'h10, 0, 'h10, 1, 0, 0}, '{3, 'h10, 'h3C, 0, 0, 1, 1},
    '{0, 'h10, 0, 'h3C, 1, 0, 0}, '{8, 'h20, 'hC3, 0, 0, 1, 1}, '{0, 'h20, 0, 'hC3, 1, 0, 0},
    '{2, 0, 0, 0, 0, 0, 0}, '{0, 0, 0, 'h6B, 1, 0, 0}, '{0, 1, 0, 'h4D, 1, 0, 0},
    '{0, 'h2002, 0, 1, 1, 0, 0}, '{0, 'h4002, 0, 0, 1, 0, 0}, '{1, 'h777, 0, 0, 0, 0, 0},
    '{0, 1, 0, 1, 1, 0, 0}, '{2, 0, 0, 0, 0, 0, 0}, '{9, 0, 0, 0, 0, 0, 0},
    '{0, 'h30, 0, 'h30, 1, 0, 0}, '{5, 0, 0, 0, 0, 1, 0}, '{6, 0, 0, 0, 0, 0, 0},
    '{0, 'h10, 0, 'h3C, 1, 0, 0}, '{7, 0, 0, 0, 0, 1, 1}, '{0, 'h10, 0, 'hFF, 1, 0, 0},
    '{4, 0, 0, 0, 0, 1, 1}};
  always #10 clk_sys = ~clk_sys;
  // wire level: host, then device, else the inverse of the last driven value
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : mdl_en ? mdl_dq : ~dq_hold;
  always @(posedge clk_sys) if (flash_dq_oe || mdl_en) dq_hold <= flash_dq_in;
  fbc_host u_dut (.clk_sys, .rst_n, .req_valid, .req_op, .req_addr, .req_data, .req_ready,
    .rsp_valid, .rsp_data, .dev_busy, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
    .flash_cs_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_done_flag);
  fbc_flash_model u_mdl (.clk_sys, .flash_addr, .flash_dq(flash_dq_in), .flash_cs_n,
    .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_done_flag, .mdl_en, .mdl_dq);
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    for (int n = 0; s !== v; n++)
    begin
      @(negedge clk_sys);
      if (n == lim) check("wait timeout", {7'h00, s}, {7'h00, v});
      if (n == lim) tally_and_finish();
    end
  endtask
  task automatic do_op(input logic [3:0] op, input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {req_op, req_addr, req_data, req_valid} = {op, a, d, 1'b1};
    wait_on(req_ready, 1'b1, 50);
    @(negedge clk_sys);
    req_valid = 1'b0;
    wait_on(rsp_valid, 1'b1, 200);
  endtask
  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].c) check("rsp_data", rsp_data, rows[i].x);
      repeat (4) @(negedge clk_sys);
      check("dev_busy", {7'h00, dev_busy}, {7'h00, rows[i].b});
      if (rows[i].w) wait_on(dev_busy, 1'b0, 300);
    end
    // reset cuts a program, which is then restarted
    do_op(3, 'h40, 'h77);
    do_op(9, 0, 0);
    do_op(0, 'h40, 0);
    check("aborted", rsp_data, 8'hFF);
    do_op(3, 'h40, 'h77);
    wait_on(dev_busy, 1'b0, 300);
    do_op(0, 'h40, 0);
    check("restarted", rsp_data, 8'h77);
    @(negedge clk_sys);
    rst_n = 1'b0;
    #1 check("idle pins", {req_ready, flash_dq_oe, flash_cs_n, flash_oe_n, flash_we_n,
      flash_reset_n, 2'b00}, 8'h3C);
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    do_op(0, 'h40, 0);
    check("after reset", rsp_data, 8'h77);
    tally_and_finish();
  end
endmodule
